/* File: rtl/ppfm_mux.sv */
// Pin function multiplexer for two Port A and four Port B pins.
//
// Summary of operation
// - Reset leaves every pin as input with pull-up
// - Port mode direction set per pin
// - Function chosen by system integration selects
// - Serial clock out as master, in as slave
// - Slave select marks transfer for this slave
// - Unselected slave releases master-in line
// - Slave data leads sampling edge by half
// - Master data leads sampling edge by half
// - Source A feeds outputs four and five
// - Source B feeds outputs two and three
`include "ppfm_map.svh"
`timescale 1ns/1ps
`default_nettype none
module ppfm_mux
  import ppfm_pkg::*;
#(
  parameter int NUM_PINS = `PPFM_NUM_PINS
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [NUM_PINS-1:0][`PPFM_SEL_W-1:0] fn_select,
  input wire logic [NUM_PINS-1:0] port_dir_out,
  input wire logic [NUM_PINS-1:0] port_data_out,
  output logic [NUM_PINS-1:0] port_data_in,
  input wire logic [NUM_PINS-1:0] pad_in,
  output logic [NUM_PINS-1:0] pad_out,
  output logic [NUM_PINS-1:0] pad_oe_n,
  output logic [NUM_PINS-1:0] pad_pullup,
  input wire ppfm_spi_drv_s spi_drv,
  input wire ppfm_i2c_drv_s i2c_drv,
  input wire ppfm_tmr_drv_s tmr_drv,
  output logic serial_iface_clock_in,
  output logic serial_iface_slave_select,
  output logic serial_iface_master_in,
  output logic serial_iface_master_out_in,
  output logic i2c_scl_in,
  output logic i2c_sda_in,
  output logic timer_channel_two_in,
  output logic timer_channel_three_in,
  output logic ext_pwm_source_a,
  output logic ext_pwm_source_b,
  output logic pwm_pair_four_five_ext,
  output logic pwm_pair_two_three_ext
);
  // Selection codes per pin: ALT1/ALT2/ALT3 as listed below.
  // A10: ALT1 comparator input. A11: ALT1 comparator input.
  // B0: ALT1 serial clock, ALT2 I2C clock.
  // B1: ALT1 slave select, ALT2 I2C data.
  // B2: ALT1 master-in, ALT2 timer two, ALT3 source A.
  // B3: ALT1 master-out, ALT2 timer three, ALT3 source B.
  logic [NUM_PINS-1:0] pin_sync;
  logic [NUM_PINS-1:0] next_out;
  logic [NUM_PINS-1:0] next_oe;
  logic slave_sel;

  initial begin
    if (NUM_PINS != `PPFM_NUM_PINS) $error("ppfm_mux: pin map is fixed at six pins.");
  end

  ppfm_sync #(.WIDTH(NUM_PINS)) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in(pad_in),
    .sync_out(pin_sync)
  );

  function automatic logic is_sel(input logic [`PPFM_SEL_W-1:0] s, input logic [`PPFM_SEL_W-1:0] c);
    return s == c;
  endfunction

  // Slave select pad is active low; only meaningful when routed.
  assign slave_sel = is_sel(fn_select[`PPFM_PIN_B1], `PPFM_SEL_ALT1) && !pin_sync[`PPFM_PIN_B1];

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      next_out[i] = port_data_out[i];
      next_oe[i] = port_dir_out[i];
    end
    // Comparator inputs are analog; the digital driver is released.
    if (!is_sel(fn_select[`PPFM_PIN_A10], `PPFM_SEL_PORT)) begin
      next_out[`PPFM_PIN_A10] = 1'h0;
      next_oe[`PPFM_PIN_A10] = 1'h0;
    end
    if (!is_sel(fn_select[`PPFM_PIN_A11], `PPFM_SEL_PORT)) begin
      next_out[`PPFM_PIN_A11] = 1'h0;
      next_oe[`PPFM_PIN_A11] = 1'h0;
    end
    case (fn_select[`PPFM_PIN_B0])
      `PPFM_SEL_ALT1: begin
        next_out[`PPFM_PIN_B0] = spi_drv.clk_out;
        next_oe[`PPFM_PIN_B0] = spi_drv.master && spi_drv.clk_oe;
      end
      `PPFM_SEL_ALT2: begin
        next_out[`PPFM_PIN_B0] = i2c_drv.scl_out;
        next_oe[`PPFM_PIN_B0] = i2c_drv.scl_oe;
      end
      `PPFM_SEL_PORT: begin
      end
      default: begin
        next_out[`PPFM_PIN_B0] = 1'h0;
        next_oe[`PPFM_PIN_B0] = 1'h0;
      end
    endcase
    case (fn_select[`PPFM_PIN_B1])
      `PPFM_SEL_ALT1: begin
        next_out[`PPFM_PIN_B1] = 1'h0;
        next_oe[`PPFM_PIN_B1] = 1'h0;
      end
      `PPFM_SEL_ALT2: begin
        next_out[`PPFM_PIN_B1] = i2c_drv.sda_out;
        next_oe[`PPFM_PIN_B1] = i2c_drv.sda_oe;
      end
      `PPFM_SEL_PORT: begin
      end
      default: begin
        next_out[`PPFM_PIN_B1] = 1'h0;
        next_oe[`PPFM_PIN_B1] = 1'h0;
      end
    endcase
    case (fn_select[`PPFM_PIN_B2])
      `PPFM_SEL_ALT1: begin
        // The shifter updates the data half a clock ahead of the sample edge.
        next_out[`PPFM_PIN_B2] = spi_drv.miso_out;
        // A master listens here; an unselected slave floats the line.
        next_oe[`PPFM_PIN_B2] = !spi_drv.master && slave_sel && spi_drv.miso_oe;
      end
      `PPFM_SEL_ALT2: begin
        next_out[`PPFM_PIN_B2] = tmr_drv.ch2_out;
        next_oe[`PPFM_PIN_B2] = tmr_drv.ch2_oe;
      end
      `PPFM_SEL_ALT3: begin
        next_out[`PPFM_PIN_B2] = 1'h0;
        next_oe[`PPFM_PIN_B2] = 1'h0;
      end
      default: begin
      end
    endcase
    case (fn_select[`PPFM_PIN_B3])
      `PPFM_SEL_ALT1: begin
        next_out[`PPFM_PIN_B3] = spi_drv.mosi_out;
        next_oe[`PPFM_PIN_B3] = spi_drv.master && spi_drv.mosi_oe;
      end
      `PPFM_SEL_ALT2: begin
        next_out[`PPFM_PIN_B3] = tmr_drv.ch3_out;
        next_oe[`PPFM_PIN_B3] = tmr_drv.ch3_oe;
      end
      `PPFM_SEL_ALT3: begin
        next_out[`PPFM_PIN_B3] = 1'h0;
        next_oe[`PPFM_PIN_B3] = 1'h0;
      end
      default: begin
      end
    endcase
  end

  // Pad drive is registered so the pads never see combinational glitches.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pad_out <= '0;
      pad_oe_n <= ~`PPFM_RST_DIR;
      pad_pullup <= `PPFM_RST_PULLUP;
    end else begin
      pad_out <= next_out;
      pad_oe_n <= ~next_oe;
      pad_pullup <= ~next_oe;
    end
  end

  // Peripheral-side inputs; all but port_data_in are gated to their idle level when not routed.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      port_data_in <= '0;
      serial_iface_clock_in <= 1'h0;
      serial_iface_slave_select <= 1'h0;
      serial_iface_master_in <= 1'h0;
      serial_iface_master_out_in <= 1'h0;
      i2c_scl_in <= 1'h1;
      i2c_sda_in <= 1'h1;
      timer_channel_two_in <= 1'h0;
      timer_channel_three_in <= 1'h0;
      ext_pwm_source_a <= 1'h0;
      ext_pwm_source_b <= 1'h0;
      pwm_pair_four_five_ext <= 1'h0;
      pwm_pair_two_three_ext <= 1'h0;
    end else begin
      port_data_in <= pin_sync;
      serial_iface_clock_in <= is_sel(fn_select[`PPFM_PIN_B0], `PPFM_SEL_ALT1)
        && !spi_drv.master && pin_sync[`PPFM_PIN_B0];
      serial_iface_slave_select <= slave_sel;
      serial_iface_master_in <= is_sel(fn_select[`PPFM_PIN_B2], `PPFM_SEL_ALT1)
        && spi_drv.master && pin_sync[`PPFM_PIN_B2];
      serial_iface_master_out_in <= is_sel(fn_select[`PPFM_PIN_B3], `PPFM_SEL_ALT1)
        && !spi_drv.master && pin_sync[`PPFM_PIN_B3];
      i2c_scl_in <= !is_sel(fn_select[`PPFM_PIN_B0], `PPFM_SEL_ALT2) || pin_sync[`PPFM_PIN_B0];
      i2c_sda_in <= !is_sel(fn_select[`PPFM_PIN_B1], `PPFM_SEL_ALT2) || pin_sync[`PPFM_PIN_B1];
      timer_channel_two_in <= is_sel(fn_select[`PPFM_PIN_B2], `PPFM_SEL_ALT2)
        && pin_sync[`PPFM_PIN_B2];
      timer_channel_three_in <= is_sel(fn_select[`PPFM_PIN_B3], `PPFM_SEL_ALT2)
        && pin_sync[`PPFM_PIN_B3];
      ext_pwm_source_a <= is_sel(fn_select[`PPFM_PIN_B2], `PPFM_SEL_ALT3)
        && pin_sync[`PPFM_PIN_B2];
      ext_pwm_source_b <= is_sel(fn_select[`PPFM_PIN_B3], `PPFM_SEL_ALT3)
        && pin_sync[`PPFM_PIN_B3];
      pwm_pair_four_five_ext <= is_sel(fn_select[`PPFM_PIN_B2], `PPFM_SEL_ALT3);
      pwm_pair_two_three_ext <= is_sel(fn_select[`PPFM_PIN_B3], `PPFM_SEL_ALT3);
    end
  end

  a_reset_input: assert property (@(posedge clk_sys) !reset_n |=> pad_oe_n == '1 && pad_pullup == '1)
    else $error("Pins not input with pull-up after reset.");
  a_port_dir: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_sel(fn_select[`PPFM_PIN_A10], `PPFM_SEL_PORT) |=> pad_oe_n[`PPFM_PIN_A10] == !$past(port_dir_out[`PPFM_PIN_A10]))
    else $error("Port direction not followed.");
  a_clk_master: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_sel(fn_select[`PPFM_PIN_B0], `PPFM_SEL_ALT1) && spi_drv.master && spi_drv.clk_oe |=> !pad_oe_n[`PPFM_PIN_B0])
    else $error("Master clock not driven.");
  a_clk_slave: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_sel(fn_select[`PPFM_PIN_B0], `PPFM_SEL_ALT1) && !spi_drv.master |=> pad_oe_n[`PPFM_PIN_B0])
    else $error("Slave drives serial clock.");
  a_miso_float: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !slave_sel |=> pad_oe_n[`PPFM_PIN_B2] || !$past(is_sel(fn_select[`PPFM_PIN_B2], `PPFM_SEL_ALT1)))
    else $error("Unselected slave drives master-in line.");
  a_miso_data: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_sel(fn_select[`PPFM_PIN_B2], `PPFM_SEL_ALT1) |=> pad_out[`PPFM_PIN_B2] == $past(spi_drv.miso_out))
    else $error("Master-in data not forwarded.");
  a_mosi_data: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_sel(fn_select[`PPFM_PIN_B3], `PPFM_SEL_ALT1) |=> pad_out[`PPFM_PIN_B3] == $past(spi_drv.mosi_out))
    else $error("Master-out data not forwarded.");
  a_src_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_sel(fn_select[`PPFM_PIN_B2], `PPFM_SEL_ALT3) ##1 is_sel(fn_select[`PPFM_PIN_B2], `PPFM_SEL_ALT3)
    |=> ext_pwm_source_a == $past(pin_sync[`PPFM_PIN_B2]) && pwm_pair_four_five_ext)
    else $error("Source A not delivered.");
  a_src_b: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_sel(fn_select[`PPFM_PIN_B3], `PPFM_SEL_ALT3) |=> ext_pwm_source_b == $past(pin_sync[`PPFM_PIN_B3]))
    else $error("Source B not delivered.");
  a_sel_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
    slave_sel |=> serial_iface_slave_select)
    else $error("Slave select not reported.");
  c_spi_master: cover property (@(posedge clk_sys) spi_drv.master && !pad_oe_n[`PPFM_PIN_B0]);
  c_slave_sel: cover property (@(posedge clk_sys) serial_iface_slave_select && !pad_oe_n[`PPFM_PIN_B2]);
  c_src_a: cover property (@(posedge clk_sys) ext_pwm_source_a);
  c_i2c: cover property (@(posedge clk_sys) !i2c_sda_in);
endmodule
`default_nettype wire

/* File: rtl/ppfm_map.svh */
// Constants for the port pin function multiplexer.
`ifndef PPFM_MAP_SVH
`define PPFM_MAP_SVH
`define PPFM_NUM_PINS 6
`define PPFM_SEL_W 2
`define PPFM_PIN_A10 0
`define PPFM_PIN_A11 1
`define PPFM_PIN_B0 2
`define PPFM_PIN_B1 3
`define PPFM_PIN_B2 4
`define PPFM_PIN_B3 5
`define PPFM_SEL_PORT 2'h0
`define PPFM_SEL_ALT1 2'h1
`define PPFM_SEL_ALT2 2'h2
`define PPFM_SEL_ALT3 2'h3
`define PPFM_RST_DIR 6'h00
`define PPFM_RST_PULLUP 6'h3F
`endif

/* File: rtl/ppfm_pkg.sv */
// Types for the port pin function multiplexer.
package ppfm_pkg;
  typedef enum logic [1:0] {
    PPFM_FN_PORT,
    PPFM_FN_ALT1,
    PPFM_FN_ALT2,
    PPFM_FN_ALT3
  } ppfm_fn_e;
  typedef struct packed {
    logic clk_out;
    logic clk_oe;
    logic master;
    logic miso_out;
    logic miso_oe;
    logic mosi_out;
    logic mosi_oe;
  } ppfm_spi_drv_s;
  typedef struct packed {
    logic scl_out;
    logic scl_oe;
    logic sda_out;
    logic sda_oe;
  } ppfm_i2c_drv_s;
  typedef struct packed {
    logic ch2_out;
    logic ch2_oe;
    logic ch3_out;
    logic ch3_oe;
  } ppfm_tmr_drv_s;
endpackage

/* File: rtl/ppfm_sync.sv */
// Two-stage synchroniser for the pad inputs.
`timescale 1ns/1ps
`default_nettype none
module ppfm_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  initial begin
    if (WIDTH < 1) $error("ppfm_sync: WIDTH must be positive.");
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      // Start at the pulled-up pad level, so no false low appears on release.
      stage1 <= '1;
      sync_out <= '1;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

/* File: dv/ppfm_ext_dev.sv */
// Far-side model: external SPI master and pad wiring for the six pins.
`timescale 1ns/1ps
`default_nettype none
module ppfm_ext_dev (
  input wire logic clk_sys,
  input wire logic spi_go,
  input wire logic [5:0] pad_out,
  input wire logic [5:0] pad_oe_n,
  input wire logic [5:0] pad_pullup,
  input wire logic [5:0] ext_oe,
  input wire logic [5:0] ext_val,
  output logic [5:0] pad_in
);
  logic sck = 1'h0;
  logic [7:0] shift = 8'hA5;
  logic [5:0] flip = 6'h15;
  logic [5:0] drv_oe;
  logic [5:0] drv_val;
  // The clock stands still outside a frame, as a real master's would.
  always @(posedge clk_sys) begin
    flip <= ~flip;
    if (spi_go) begin
      sck <= ~sck;
      if (sck) begin
        shift <= {shift[6:0], shift[7]};
      end
    end
  end
  always_comb begin
    drv_oe = spi_go ? (ext_oe | 6'h2C) : ext_oe;
    drv_val = spi_go ? {shift[7], ext_val[4], 1'h0, ext_val[2] & 1'h0, 1'h0, 1'h0} : ext_val;
    drv_val[2] = spi_go ? sck : ext_val[2];
    drv_val[1:0] = ext_val[1:0];
    for (int i = 0; i < 6; i++) begin
      // A released pin floats to the pull-up or else reads as noise.
      if (!pad_oe_n[i]) begin
        pad_in[i] = pad_out[i];
      end else if (drv_oe[i]) begin
        pad_in[i] = drv_val[i];
      end else begin
        pad_in[i] = pad_pullup[i] ? 1'h1 : flip[i];
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/ppfm_mux_tb.sv */
// Self-checking bench for the port pin function multiplexer.
`timescale 1ns/1ps
`default_nettype none
module ppfm_mux_tb import ppfm_pkg::*;;
  logic clk_sys = 1'h0;
  logic reset_n = 1'h0;
  logic spi_go;
  logic [5:0][1:0] fn_select;
  logic [5:0] port_dir_out, port_data_out, port_data_in, pad_in, pad_out, pad_oe_n;
  logic [5:0] pad_pullup, ext_oe, ext_val;
  logic [2:0][5:0] hist;
  ppfm_spi_drv_s spi_drv;
  ppfm_i2c_drv_s i2c_drv;
  ppfm_tmr_drv_s tmr_drv;
  logic serial_iface_clock_in, serial_iface_slave_select, serial_iface_master_in;
  logic serial_iface_master_out_in, i2c_scl_in, i2c_sda_in, timer_channel_two_in;
  logic timer_channel_three_in, ext_pwm_source_a, ext_pwm_source_b;
  logic pwm_pair_four_five_ext, pwm_pair_two_three_ext;
  int bad_count = 0;
  int tests_run = 0;
  always #5 clk_sys = ~clk_sys;
  // Pad history mirrors the two-stage sync plus output register.
  always @(posedge clk_sys) hist <= {hist[1:0], pad_in};
  ppfm_mux i_dut (.clk_sys, .reset_n, .fn_select, .port_dir_out, .port_data_out,
    .port_data_in, .pad_in, .pad_out, .pad_oe_n, .pad_pullup, .spi_drv, .i2c_drv,
    .tmr_drv, .serial_iface_clock_in, .serial_iface_slave_select, .serial_iface_master_in,
    .serial_iface_master_out_in, .i2c_scl_in, .i2c_sda_in, .timer_channel_two_in,
    .timer_channel_three_in, .ext_pwm_source_a, .ext_pwm_source_b,
    .pwm_pair_four_five_ext, .pwm_pair_two_three_ext);
  ppfm_ext_dev i_ext (.clk_sys, .spi_go, .pad_out, .pad_oe_n, .pad_pullup, .ext_oe,
    .ext_val, .pad_in);
  task automatic check(input logic [5:0] got, input logic [5:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t mismatch got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic t_port;
    port_dir_out = 6'h15;
    port_data_out = 6'h3C;
    ext_oe = 6'h2A;
    ext_val = 6'h08;
    cyc(4);
    check(pad_oe_n, 6'h2A);
    check(pad_out & 6'h15, 6'h14);
    check(port_data_in, 6'h1C);
    check(pad_pullup, 6'h2A);
    port_dir_out = 6'h00;
    ext_oe = 6'h00;
  endtask
  task automatic t_spi_slave;
    fn_select = {2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0};
    spi_drv = '{clk_out: 1'h0, clk_oe: 1'h0, master: 1'h0, miso_out: 1'h1, miso_oe: 1'h1,
      mosi_out: 1'h0, mosi_oe: 1'h0};
    cyc(4);
    check(pad_oe_n[4], 1'h1);
    check(serial_iface_slave_select, 1'h0);
    spi_go = 1'h1;
    for (int i = 0; i < 14; i++) begin
      cyc(1);
      if (i >= 4) begin
        check(serial_iface_master_out_in, hist[2][5]);
        check(serial_iface_clock_in, hist[2][2]);
      end
    end
    check(serial_iface_slave_select, 1'h1);
    check(pad_oe_n[4], 1'h0);
    check(pad_out[4], 1'h1);
    spi_go = 1'h0;
  endtask
  task automatic t_spi_master;
    spi_drv = '{clk_out: 1'h1, clk_oe: 1'h1, master: 1'h1, miso_out: 1'h1, miso_oe: 1'h1,
      mosi_out: 1'h1, mosi_oe: 1'h1};
    ext_oe = 6'h10;
    ext_val = 6'h10;
    cyc(5);
    check({pad_oe_n[2], pad_out[2], serial_iface_clock_in}, 3'h2);
    check({pad_oe_n[5], pad_out[5]}, 2'h1);
    check({pad_oe_n[4], serial_iface_master_in}, 2'h3);
  endtask
  task automatic t_alt;
    fn_select = {2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h0};
    port_dir_out = 6'h0F;
    ext_oe = 6'h30;
    ext_val = 6'h10;
    cyc(5);
    check(pad_oe_n[3:0], 4'hE);
    check({ext_pwm_source_a, pwm_pair_four_five_ext}, 2'h3);
    check({ext_pwm_source_b, pwm_pair_two_three_ext}, 2'h1);
    fn_select = {2'h2, 2'h2, 2'h2, 2'h2, 2'h0, 2'h0};
    tmr_drv = '{ch2_out: 1'h1, ch2_oe: 1'h1, ch3_out: 1'h0, ch3_oe: 1'h0};
    i2c_drv = '{scl_out: 1'h0, scl_oe: 1'h1, sda_out: 1'h1, sda_oe: 1'h0};
    ext_oe = 6'h28;
    ext_val = 6'h20;
    cyc(5);
    check({pad_oe_n[4], pad_out[4], timer_channel_three_in}, 3'h3);
    check({pad_oe_n[2], pad_out[2], i2c_sda_in}, 3'h0);
    check({i2c_scl_in, timer_channel_two_in}, 2'h1);
    check(pwm_pair_four_five_ext, 1'h0);
  endtask
  initial begin
    fn_select = '0;
    port_dir_out = 6'h00;
    port_data_out = 6'h00;
    spi_drv = '0;
    i2c_drv = '0;
    tmr_drv = '0;
    ext_oe = 6'h00;
    ext_val = 6'h00;
    spi_go = 1'h0;
    cyc(11);
    check(pad_oe_n, 6'h3F);
    check(pad_pullup, 6'h3F);
    cyc(1);
    reset_n = 1'h1;
    cyc(4);
    check(pad_oe_n, 6'h3F);
    check(port_data_in, 6'h3F);
    t_port();
    t_spi_slave();
    t_spi_master();
    t_alt();
    finish_test();
  end
endmodule
`default_nettype wire
